// *** rtl/timer8_with_shared_prescaler.sv ***
// What this block does
// - Counter adds one on each active timer clock enable, one system clock only.
// - Clock select zero stops counting; software still reads and writes the counter.
// - Software counter write beats any count in the same cycle, accepted anytime.
// - Counter only counts up, never self-clears, wraps from 0xFF to 0x00.
// - Overflow flag sets when counting wraps the counter to zero; counting never clears it.
// - Select 0 stop, 1 undivided, 2 to 5 prescaler taps 8, 64, 256, 1024.
// - Select 6 counts falling pin edges, 7 rising; one pulse per edge.
// - Pin edges count even when the pin is driven as an output.
// - Interrupt requested while overflow enable, global enable and flag are all set.
// - Flag clears on vector execution or on software writing a one.
// - Prescaler runs freely, shared with the second timer, each picking its tap.
// - Prescaler is not resynchronised on enable; first count takes 1 to N+1.
// - Pin sampled each clock through synchroniser, then edge detector, then counter.
// - Synchroniser uses rising-edge flops and a latch transparent while clock high.
// - Counter updates 2.5 to 3.5 clocks after a pin edge.
// - Pin pulses go straight to the counter, never through the prescaler.
// - Writing one to prescaler reset clears it for both timers; reads zero.
//
// Design decisions made here: the APB slave port and the address map.
`include "timer8_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module timer8_with_shared_prescaler
    import timer8_pkg::*;
#(
    parameter int ADDR_W  = 8,
    parameter int PRESC_W = `TMR_PRESC_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              count_pin,
    input  wire logic              global_irq_enable,
    input  wire logic              ovf_vector_ack,
    input  wire logic [2:0]        second_clock_select,
    output logic                   ovf_irq,
    output logic                   timer_clock_enable,
    output logic                   second_timer_tick
);

    generate
        if (ADDR_W < 8 || PRESC_W != `TMR_PRESC_W) begin : g_bad_params
            $error("timer8: ADDR_W must be at least 8 and PRESC_W must be 10");
        end
    endgenerate

    // Decoding is shared by the read path and the write path.
    function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
        reg_sel_e sel;
        logic [ADDR_W-1:0] high_bits;
        high_bits = a & ~ADDR_W'(`TMR_OFF_MASK_LOW);
        sel = sel_none;
        if (high_bits == '0) begin
            unique case (a[7:0])
                `TMR_OFF_CONTROL: sel = sel_control;
                `TMR_OFF_COUNT:   sel = sel_count;
                `TMR_OFF_MASK:    sel = sel_mask;
                `TMR_OFF_FLAGS:   sel = sel_flags;
                `TMR_OFF_SPECIAL: sel = sel_special;
                default:          sel = sel_none;
            endcase
        end
        return sel;
    endfunction

    // Timer clock enable for a given select; used for this timer and the second one.
    function automatic logic tap_tick(
        input clk_src_e           src,
        input logic [PRESC_W-1:0] p,
        input logic               rise,
        input logic               fall
    );
        logic t;
        t = 1'b0;
        unique case (src)
            src_stop:     t = 1'b0;
            src_div1:     t = 1'b1;
            src_div8:     t = &p[`TMR_TAP8_BITS-1:0];
            src_div64:    t = &p[`TMR_TAP64_BITS-1:0];
            src_div256:   t = &p[`TMR_TAP256_BITS-1:0];
            src_div1024:  t = &p[`TMR_TAP1024_BITS-1:0];
            src_ext_fall: t = fall;
            src_ext_rise: t = rise;
        endcase
        return t;
    endfunction

    count_edge_if pin_edges ();

    count_pin_sync u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .count_pin (count_pin),
        .edges     (pin_edges)
    );

    // Register state.
    logic [`TMR_CS_MSB:`TMR_CS_LSB] clock_select_field;
    logic [`TMR_REG_W-1:0]          timer_count_value;
    logic                           overflow_irq_enable;
    logic                           overflow_flag;
    logic [PRESC_W-1:0]             presc;

    logic [`TMR_CS_MSB:`TMR_CS_LSB] next_clock_select_field;
    logic [`TMR_REG_W-1:0]          next_timer_count_value;
    logic                           next_overflow_irq_enable;
    logic                           next_overflow_flag;
    logic [PRESC_W-1:0]             next_presc;
    logic                           next_ovf_irq;
    logic                           next_timer_clock_enable;
    logic                           next_second_timer_tick;

    // Bus answer state.
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    reg_sel_e              sel;
    logic                  wr_commit;
    logic                  lane_ok;
    logic [`TMR_REG_W-1:0] wbyte;
    logic [`TMR_REG_W-1:0] rbyte;
    logic                  tick;
    logic                  ovf_set;
    logic                  ovf_clr;
    logic                  wr_count;
    logic                  psr_write;

    assign sel     = decode(paddr);
    assign lane_ok = pstrb[`TMR_BYTE_LANE];
    assign wbyte   = pwdata[`TMR_REG_W-1:0];

    // A write lands only at the edge where pready is seen high.
    assign wr_commit = psel & penable & pready & pwrite & lane_ok;
    assign wr_count  = wr_commit & (sel == sel_count);
    assign psr_write = wr_commit & (sel == sel_special) & wbyte[`TMR_PSR_BIT];

    assign tick = tap_tick(clk_src_e'(clock_select_field), presc,
                           pin_edges.rise, pin_edges.fall);

    // A counter write suppresses both the count and its overflow.
    assign ovf_set = tick & ~wr_count & (timer_count_value == `TMR_COUNT_MAX);
    assign ovf_clr = ovf_vector_ack
                   | (wr_commit & (sel == sel_flags) & wbyte[`TMR_OVF_FLAG_BIT]);

    always_comb begin
        rbyte = '0;
        unique case (sel)
            sel_control: rbyte[`TMR_CS_MSB:`TMR_CS_LSB] = clock_select_field;
            sel_count:   rbyte = timer_count_value;
            sel_mask:    rbyte[`TMR_OVF_IE_BIT] = overflow_irq_enable;
            sel_flags:   rbyte[`TMR_OVF_FLAG_BIT] = overflow_flag;
            sel_special: rbyte = '0;
            sel_none:    rbyte = '0;
            default:     rbyte = '0;
        endcase
    end

    // Zero-wait-free slave: one access cycle to prepare, pready in the next.
    always_comb begin
        next_pready  = psel & penable & ~pready;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (psel & penable & ~pready) begin
            next_prdata  = {{(32 - `TMR_REG_W){1'b0}}, rbyte};
            next_pslverr = (sel == sel_none);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Timer state.
    always_comb begin
        next_clock_select_field  = clock_select_field;
        next_overflow_irq_enable = overflow_irq_enable;
        next_timer_count_value   = timer_count_value;
        if (wr_commit && sel == sel_control) begin
            next_clock_select_field = wbyte[`TMR_CS_MSB:`TMR_CS_LSB];
        end
        if (wr_commit && sel == sel_mask) begin
            next_overflow_irq_enable = wbyte[`TMR_OVF_IE_BIT];
        end
        if (wr_count) begin
            next_timer_count_value = wbyte;
        end else if (tick) begin
            next_timer_count_value = timer_count_value + 1'b1;
        end
        // A new overflow in the clearing cycle must not be lost.
        next_overflow_flag = (overflow_flag & ~ovf_clr) | ovf_set;
        // Free running; only the reset bit disturbs it, never a select change.
        next_presc = psr_write ? '0 : presc + 1'b1;
        next_ovf_irq = next_overflow_flag & next_overflow_irq_enable
                     & global_irq_enable;
        next_timer_clock_enable = tick;
        // The second timer has no pin path here, so its external codes stay idle.
        next_second_timer_tick = tap_tick(clk_src_e'(second_clock_select), presc,
                                          1'b0, 1'b0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_select_field  <= `TMR_CS_RESET;
            timer_count_value   <= `TMR_COUNT_RESET;
            overflow_irq_enable <= 1'b0;
            overflow_flag       <= 1'b0;
            presc               <= '0;
            ovf_irq             <= 1'b0;
            timer_clock_enable  <= 1'b0;
            second_timer_tick   <= 1'b0;
        end else begin
            clock_select_field  <= next_clock_select_field;
            timer_count_value   <= next_timer_count_value;
            overflow_irq_enable <= next_overflow_irq_enable;
            overflow_flag       <= next_overflow_flag;
            presc               <= next_presc;
            ovf_irq             <= next_ovf_irq;
            timer_clock_enable  <= next_timer_clock_enable;
            second_timer_tick   <= next_second_timer_tick;
        end
    end

endmodule // timer8_with_shared_prescaler

`default_nettype wire

// *** rtl/timer8_consts.svh ***
`ifndef TIMER8_CONSTS_SVH
`define TIMER8_CONSTS_SVH

// Register byte offsets on the APB.
`define TMR_OFF_CONTROL   8'h00
`define TMR_OFF_COUNT     8'h04
`define TMR_OFF_MASK      8'h08
`define TMR_OFF_FLAGS     8'h0C
`define TMR_OFF_SPECIAL   8'h10
`define TMR_OFF_MASK_LOW  8'hFF

// Field layout.
`define TMR_REG_W         8
`define TMR_CS_LSB        0
`define TMR_CS_MSB        2
`define TMR_OVF_IE_BIT    0
`define TMR_OVF_FLAG_BIT  0
`define TMR_PSR_BIT       0
`define TMR_BYTE_LANE     0

// Reset values and the count maximum.
`define TMR_COUNT_RESET   8'h00
`define TMR_CS_RESET      3'h0
`define TMR_COUNT_MAX     8'hFF

// Prescaler width and tap widths (divide by 8, 64, 256, 1024).
`define TMR_PRESC_W       10
`define TMR_TAP8_BITS     3
`define TMR_TAP64_BITS    6
`define TMR_TAP256_BITS   8
`define TMR_TAP1024_BITS  10

`endif

// *** rtl/timer8_pkg.sv ***
package timer8_pkg;

    // Clock-select codes in numeric order, zero stops the timer.
    typedef enum logic [2:0] {
        src_stop,
        src_div1,
        src_div8,
        src_div64,
        src_div256,
        src_div1024,
        src_ext_fall,
        src_ext_rise
    } clk_src_e;

    typedef enum logic [2:0] {
        sel_control,
        sel_count,
        sel_mask,
        sel_flags,
        sel_special,
        sel_none
    } reg_sel_e;

endpackage

// *** rtl/count_edge_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface count_edge_if;
    logic rise;
    logic fall;

    modport source (output rise, output fall);
    modport sink   (input rise, input fall);
endinterface

`default_nettype wire

// *** rtl/count_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module count_pin_sync (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        count_pin,
    count_edge_if.source     edges
);

    logic pin_latched;
    logic stage1;
    logic stage2;
    logic stage3;
    logic next_stage1;
    logic next_stage2;
    logic next_stage3;

    // Transparent while the clock is high, so the pin is held across the falling half.
    always_latch begin
        if (pclk) begin
            // Non-blocking, so the first flop still takes the held value at the opening edge.
            pin_latched <= count_pin;
        end
    end

    always_comb begin
        next_stage1 = pin_latched;
        next_stage2 = stage1;
        next_stage3 = stage2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
        end
    end

    // One pulse per edge; the pin's direction plays no part here.
    assign edges.rise = stage2 & ~stage3;
    assign edges.fall = ~stage2 & stage3;

endmodule // count_pin_sync

`default_nettype wire

// *** testbench/count_source.sv ***
`timescale 1ns/100ps
`default_nettype none

module count_source (
    output logic count_pin
);
    // The source idles low and stable between bursts, so enabling pin clocking sees no change.
    initial count_pin = 1'b0;

    // Each half period of 12 ns exceeds one system clock and keeps under fclk/2.5.
    // The first change is moved off the clock edges, so the pin never moves with either edge.
    task automatic pulses(input int n, input int half_ns);
        #1;
        repeat (n) begin
            #(half_ns) count_pin = 1'b1;
            #(half_ns) count_pin = 1'b0;
        end
    endtask
endmodule // count_source

`default_nettype wire

// *** testbench/timer8_monitor.sv ***
`include "timer8_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module timer8_monitor #(
    parameter int ADDR_W = 8
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              count_pin,
    input wire logic              global_irq_enable,
    input wire logic [2:0]        second_clock_select,
    input wire logic              ovf_irq,
    input wire logic              timer_clock_enable,
    input wire logic              second_timer_tick
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The select field is not a port, so it is mirrored from writes that land.
    logic [2:0] sel;
    wire logic  mapped = paddr inside {`TMR_OFF_CONTROL, `TMR_OFF_COUNT, `TMR_OFF_MASK,
                                       `TMR_OFF_FLAGS, `TMR_OFF_SPECIAL};
    wire logic  ctl_wr = psel && penable && pready && pwrite && pstrb[0]
                         && paddr == `TMR_OFF_CONTROL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel <= 3'h0;
        end else if (ctl_wr) begin
            sel <= pwdata[2:0];
        end
    end

    ready_single_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    err_decode_a: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    upper_zero_a: assert property (prdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    reset_reads_zero_a: assert property (pready && !pwrite && paddr == `TMR_OFF_SPECIAL |-> prdata == 32'h0)
        else $error("prescaler reset bit read back nonzero");
    stop_quiet_a: assert property (sel == 3'h0 |=> !timer_clock_enable)
        else $error("timer clock active while stopped");
    direct_tick_a: assert property (sel == 3'h1 |=> timer_clock_enable)
        else $error("undivided clock missed a count");
    rise_delay_a: assert property (sel == 3'h7 && $rose(count_pin) |-> ##[2:4] timer_clock_enable)
        else $error("rising pin edge not counted in time");
    fall_delay_a: assert property (sel == 3'h6 && $fell(count_pin) |-> ##[2:4] timer_clock_enable)
        else $error("falling pin edge not counted in time");
    irq_gate_a: assert property (ovf_irq |-> $past(global_irq_enable))
        else $error("overflow request without global enable");
    tap_off_a: assert property (second_clock_select inside {3'h0, 3'h6, 3'h7} |=> !second_timer_tick)
        else $error("second timer tick with no prescaled tap");
endmodule // timer8_monitor

bind timer8_with_shared_prescaler timer8_monitor #(.ADDR_W(ADDR_W)) mon (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_pin(count_pin), .global_irq_enable(global_irq_enable),
    .second_clock_select(second_clock_select), .ovf_irq(ovf_irq),
    .timer_clock_enable(timer_clock_enable), .second_timer_tick(second_timer_tick)
);

`default_nettype wire

// *** testbench/tb.sv ***
`include "timer8_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic        pclk, presetn, psel, penable, pwrite, gie, ack;
    logic [7:0]  paddr, a;
    logic [31:0] pwdata, prdata, rd_v;
    logic [3:0]  pstrb;
    logic [2:0]  sel2;
    logic        pready, pslverr, irq, tce, tick, pin, err_v;
    int          n_mismatch, check_count, n;
    int          sh[8] = '{0, 0, 3, 6, 8, 10, 0, 0};

    timer8_with_shared_prescaler dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_pin(pin),
        .global_irq_enable(gie), .ovf_vector_ack(ack), .second_clock_select(sel2),
        .ovf_irq(irq), .timer_clock_enable(tce), .second_timer_tick(tick));
    count_source src (.count_pin(pin));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic print_verdict();
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            print_verdict();
        end
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        xfer(1'b1, ad, d);
    endtask

    task automatic rd(input logic [7:0] ad);
        xfer(1'b0, ad, 8'h00);
    endtask

    // Stopping right after the start keeps a second overflow out of the flag checks.
    task automatic run_over(input logic [7:0] start);
        wr(`TMR_OFF_COUNT, start);
        wr(`TMR_OFF_CONTROL, 8'h01);
        wr(`TMR_OFF_CONTROL, 8'h00);
    endtask

    initial begin
        {psel, penable, pwrite, gie, ack} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        sel2 = 3'h0;
        presetn = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(8'(4 * i));
            check(rd_v, 32'h0);
            check(err_v, 32'h0);
        end
        rd(8'h14);
        check(err_v, 32'h1);
        wr(`TMR_OFF_COUNT, 8'hA5);
        repeat (20) @(posedge pclk);
        rd(`TMR_OFF_COUNT);
        check(rd_v, 32'hA5);
        wr(`TMR_OFF_CONTROL, 8'h01);
        wr(`TMR_OFF_COUNT, 8'h40);
        check(tce, 32'h1);
        rd(`TMR_OFF_COUNT);
        check(rd_v inside {[32'h41:32'h45]}, 32'h1);
        a = rd_v[7:0];
        rd(`TMR_OFF_COUNT);
        check(8'(rd_v[7:0] - a), 32'h4);
        wr(`TMR_OFF_CONTROL, 8'h00);
        wr(`TMR_OFF_COUNT, 8'h00);
        wr(`TMR_OFF_CONTROL, 8'h03);
        repeat (640) @(posedge pclk);
        rd(`TMR_OFF_COUNT);
        check(rd_v inside {32'hA, 32'hB}, 32'h1);
        wr(`TMR_OFF_CONTROL, 8'h00);
        wr(`TMR_OFF_MASK, 8'h01);
        gie <= 1'b1;
        run_over(8'hFE);
        check(irq, 32'h1);
        rd(`TMR_OFF_COUNT);
        check(rd_v inside {[32'h1:32'h4]}, 32'h1);
        gie <= 1'b0;
        repeat (2) @(posedge pclk);
        check(irq, 32'h0);
        gie <= 1'b1;
        wr(`TMR_OFF_FLAGS, 8'h00);
        rd(`TMR_OFF_FLAGS);
        check(rd_v, 32'h1);
        check(irq, 32'h1);
        wr(`TMR_OFF_FLAGS, 8'h01);
        rd(`TMR_OFF_FLAGS);
        check(rd_v, 32'h0);
        run_over(8'hFF);
        check(irq, 32'h1);
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
        rd(`TMR_OFF_FLAGS);
        check(rd_v, 32'h0);
        for (int c = 0; c < 8; c++) begin
            sel2 <= 3'(c);
            n = 0;
            repeat (3) @(posedge pclk);
            repeat (2048) begin
                @(posedge pclk);
                n += int'(tick);
            end
            check(n, (c >= 1 && c <= 5) ? 2048 >> sh[c] : 0);
        end
        sel2 <= 3'h5;
        repeat (300) @(posedge pclk);
        wr(`TMR_OFF_SPECIAL, 8'h01);
        n = 0;
        while (tick !== 1'b1 && n < 1100) begin
            @(posedge pclk);
            n++;
        end
        check(n inside {[1022:1027]}, 32'h1);
        rd(`TMR_OFF_SPECIAL);
        check(rd_v, 32'h0);
        wr(`TMR_OFF_COUNT, 8'h00);
        wr(`TMR_OFF_CONTROL, 8'h07);
        src.pulses(5, 12);
        repeat (8) @(posedge pclk);
        rd(`TMR_OFF_COUNT);
        check(rd_v, 32'h5);
        wr(`TMR_OFF_COUNT, 8'h00);
        wr(`TMR_OFF_CONTROL, 8'h06);
        src.pulses(4, 12);
        repeat (8) @(posedge pclk);
        rd(`TMR_OFF_COUNT);
        check(rd_v, 32'h4);
        print_verdict();
    end
endmodule // tb

`default_nettype wire
